// ===== rwi_core_model.sv
// Behavioural processor core that takes vectors offered by the control block.
`timescale 1ns/1ps
module rwi_core_model (
	// Clock and reset.
	input  wire logic               clk_i,
	input  wire logic               rst_n_i,
	// Vector offer and halt state from the block.
	input  wire rwi_pkg::rwi_vec_e  vec_sel_i,
	input  wire logic               halt_i,
	// Bench commands: bit 0 trap, 1 stop, 2 wait, 3 unmask.
	input  wire logic [3:0]         cmd_i,
	input  wire logic [1:0]         lat_i,
	// Handshake to the block and record of taken vectors.
	output rwi_pkg::rwi_core_s      core_o,
	output rwi_pkg::rwi_vec_e       taken_o,
	output int                      takes_o
);
	logic		trap_pend;
	logic		ack_q;
	logic		offered;
	logic [1:0]	wait_cnt;

	// A halted core cannot take anything, so the offer is ignored then.
	assign offered = vec_sel_i != rwi_pkg::RWI_VEC_NONE &&
		vec_sel_i != rwi_pkg::RWI_VEC_RESET && !halt_i;
	// Every cycle is an instruction boundary in this model.
	assign core_o = {1'b1, trap_pend, cmd_i[1], cmd_i[2], cmd_i[3], ack_q};

	// Take the offered vector after lat_i cycles, one pulse per take.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			trap_pend <= 1'b0;
			ack_q <= 1'b0;
			wait_cnt <= 2'd0;
			takes_o <= 0;
			taken_o <= rwi_pkg::RWI_VEC_NONE;
		end else begin
			if (cmd_i[0]) trap_pend <= 1'b1;
			ack_q <= offered && !ack_q && wait_cnt == lat_i;
			wait_cnt <= (offered && !ack_q) ? wait_cnt + 2'd1 : 2'd0;
			if (ack_q) begin
				taken_o <= vec_sel_i;
				takes_o <= takes_o + 1;
				if (vec_sel_i == rwi_pkg::RWI_VEC_TRAP) trap_pend <= 1'b0;
			end
		end
	end
endmodule // rwi_core_model

// ===== rwi_ctrl.sv
// Reset sequencing, watchdog, interrupt latching and vector selection.
`timescale 1ns/1ps
module rwi_ctrl #(
	parameter int XTAL_DELAY = rwi_pkg::XTAL_DELAY_CYC,
	parameter int STAGES     = rwi_pkg::WDOG_STAGES,
	parameter int PINS       = rwi_pkg::PORTA_PINS
) (
	// Clock and synchronous reset.
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	// Option straps, sampled while the sequencer is in POR; self_check_i is used live.
	input  wire logic                opt_rc_osc_i,
	input  wire logic                opt_wdog_en_i,
	input  wire logic                opt_level_trig_i,
	input  wire logic [PINS-1:0]     opt_porta_irq_i,
	input  wire logic                self_check_i,
	// Device pins.
	input  wire logic                osc_active_i,
	input  wire logic                reset_pin_n_i,
	input  wire logic                irq_pin_n_i,
	input  wire logic [PINS-1:0]     porta_pin_i,
	input  wire logic [PINS-1:0]     porta_direction_register_i,
	// Timer flags and enables.
	input  wire rwi_pkg::rwi_timer_s timer_i,
	// Processor core handshake.
	input  wire rwi_pkg::rwi_core_s  core_i,
	// Wishbone slave.
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [12:0]         wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	// Outputs to the core.
	output logic                     sys_reset_o,
	output logic                     set_mask_o,
	output logic                     osc_enable_o,
	output logic                     core_halt_o,
	output logic                     request_level_o,
	output rwi_pkg::rwi_vec_e        vec_sel_o,
	output logic      [12:0]         vec_addr_o
);

	localparam int RC_CNT  = (rwi_pkg::RC_DELAY_CYC * rwi_pkg::BUS_CYCLE_NS
		+ rwi_pkg::BUS_CYCLE_NS - 1) / rwi_pkg::BUS_CYCLE_NS;
	localparam logic [12:0] RC_CNT_W   = 13'(RC_CNT);
	localparam logic [12:0] XTAL_CNT_W = 13'(XTAL_DELAY);
	localparam logic [STAGES-1:0] WDOG_MAX = '1;
	localparam logic [STAGES-1:0] STOP_CNT_W =
		STAGES'(rwi_pkg::STOP_EXIT_CNT);

	typedef enum {ST_POR, ST_HOLD, ST_RUN, ST_WAIT, ST_STOP} rwi_state_e;

	rwi_state_e        state;
	logic [12:0]       delay_cnt;
	logic [STAGES-1:0] wdog_cnt;
	logic              wdog_expire;
	logic              reset_pin_n;
	logic              irq_n;
	logic [PINS-1:0]   porta;
	logic              ext_level_n;
	logic              ext_level_d;
	logic              ext_latch;
	logic              timer_req;
	logic              mask_bit;
	logic              opt_rc;
	logic              opt_wdog;
	logic              opt_level;
	logic [PINS-1:0]   opt_porta;
	logic              wb_hit;
	logic              wb_req;

	// The reset, IRQ and port A pins come from outside the clock domain and pass two flip-flops.
	rwi_sync #(.WIDTH(PINS + 2), .INIT('1)) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.async_i ({reset_pin_n_i, irq_pin_n_i, porta_pin_i}),
		.sync_o  ({reset_pin_n, irq_n, porta})
	);

	// Straps are caught by a clocked process so reset never loads a port.
	always_ff @(posedge clk_i) begin
		if (state == ST_POR) begin
			opt_rc    <= opt_rc_osc_i;
			opt_wdog  <= opt_wdog_en_i;
			opt_level <= opt_level_trig_i;
			opt_porta <= opt_porta_irq_i;
		end
	end

	// Combined request level of the pin and enabled input port A pins.
	always_comb begin
		ext_level_n = irq_n;
		for (int i = 0; i < PINS; i++) begin
			if (opt_porta[i] && !porta_direction_register_i[i]) begin
				ext_level_n = ext_level_n & porta[i];
			end
		end
	end
	assign request_level_o = ~ext_level_n;

	// Reset and low-power sequencer. Watchdog expiry re-enters POR.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || wdog_expire) begin
			state     <= ST_POR;
			delay_cnt <= '0;
		end else begin
			unique case (state)
				ST_POR: begin
					if (osc_active_i) begin
						delay_cnt <= delay_cnt + 13'h0001;
						if (delay_cnt + 13'h0001 >=
							(opt_rc ? RC_CNT_W : XTAL_CNT_W)) begin
							state <= ST_HOLD;
						end
					end
				end
				ST_HOLD: begin
					if (reset_pin_n) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!reset_pin_n) begin
						state     <= ST_POR;
						delay_cnt <= '0;
					end else if (core_i.stop_req) begin
						state <= ST_STOP;
					end else if (core_i.wait_req) begin
						state <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (!reset_pin_n) begin
						state     <= ST_POR;
						delay_cnt <= '0;
					end else if (ext_latch || timer_req) begin
						state <= ST_RUN;
					end
				end
				ST_STOP: begin
					if (!reset_pin_n) begin
						state     <= ST_POR;
						delay_cnt <= '0;
					end else if (ext_latch) begin
						state <= ST_RUN;
					end
				end
			endcase
		end
	end

	assign sys_reset_o  = (state == ST_POR) || (state == ST_HOLD);
	assign osc_enable_o = (state != ST_STOP);
	assign core_halt_o  = (state == ST_WAIT) || (state == ST_STOP);

	// Wishbone decode; ack answers one cycle after the strobe.
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_hit = wb_adr_i == rwi_pkg::WDOG_CLEAR_ADDR;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= wb_hit ? {24'h000000, rwi_pkg::SELF_CHECK_CODE}
					: 32'h00000000;
			end
		end
	end

	// Watchdog counter; software can only stop it by entering STOP.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || sys_reset_o || !opt_wdog || self_check_i) begin
			wdog_cnt <= '0;
		end else if (state == ST_STOP) begin
			wdog_cnt <= STOP_CNT_W;
		end else if (wb_req && wb_we_i && wb_hit && wb_sel_i[0]
			&& !wb_dat_i[rwi_pkg::WDOG_CLEAR_BIT]) begin
			wdog_cnt <= '0;
		end else begin
			wdog_cnt <= wdog_cnt + 1'b1;
		end
	end
	assign wdog_expire = (wdog_cnt == WDOG_MAX) && (state != ST_STOP);

	// External latch: edge always, level when the option is chosen.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || sys_reset_o) begin
			ext_level_d <= 1'b1;
			ext_latch   <= 1'b0;
		end else begin
			ext_level_d <= ext_level_n;
			if ((ext_level_d && !ext_level_n) || (opt_level && !ext_level_n)) begin
				ext_latch <= 1'b1;
			end else if (core_i.ack && vec_sel_o == rwi_pkg::RWI_VEC_EXT) begin
				ext_latch <= 1'b0;
			end
		end
	end

	// Enables gate requests; flags are set and cleared by the timer itself.
	assign timer_req = !sys_reset_o && (
		(timer_i.capture_flag  && timer_i.capture_en)  ||
		(timer_i.compare_flag  && timer_i.compare_en)  ||
		(timer_i.overflow_flag && timer_i.overflow_en));

	// Mask bit shadow: set on reset and on any taken vector.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || sys_reset_o) begin
			mask_bit <= 1'b1;
		end else if (core_i.ack) begin
			mask_bit <= 1'b1;
		end else if (core_i.mask_clear || state == ST_WAIT
			|| state == ST_STOP) begin
			mask_bit <= 1'b0;
		end
	end
	assign set_mask_o = sys_reset_o || core_i.ack;

	// Vector choice in fixed priority at an instruction boundary.
	always_comb begin
		vec_sel_o = rwi_pkg::RWI_VEC_NONE;
		if (sys_reset_o) begin
			vec_sel_o = rwi_pkg::RWI_VEC_RESET;
		end else if (core_i.boundary && core_i.trap_req) begin
			vec_sel_o = rwi_pkg::RWI_VEC_TRAP;
		end else if (core_i.boundary && !mask_bit && ext_latch) begin
			vec_sel_o = rwi_pkg::RWI_VEC_EXT;
		end else if (core_i.boundary && !mask_bit && timer_req) begin
			vec_sel_o = rwi_pkg::RWI_VEC_TIMER;
		end
	end

	// Vector address lookup.
	always_comb begin
		unique case (vec_sel_o)
			rwi_pkg::RWI_VEC_RESET: vec_addr_o = rwi_pkg::VEC_RESET;
			rwi_pkg::RWI_VEC_TRAP:  vec_addr_o = rwi_pkg::VEC_TRAP;
			rwi_pkg::RWI_VEC_EXT:   vec_addr_o = rwi_pkg::VEC_EXT;
			rwi_pkg::RWI_VEC_TIMER: vec_addr_o = rwi_pkg::VEC_TIMER;
			default:                vec_addr_o = 13'h0000;
		endcase
	end

	// Checks on the sequencing and arbitration.
	AST_TRAP_UNMASKED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!sys_reset_o && core_i.boundary && core_i.trap_req)
		|-> vec_addr_o == rwi_pkg::VEC_TRAP) else $error("trap not served");
	AST_MASK_BLOCKS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(mask_bit && !core_i.trap_req && !sys_reset_o)
		|-> vec_sel_o == rwi_pkg::RWI_VEC_NONE) else $error("masked vector");
	AST_RESET_VEC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sys_reset_o |-> (vec_addr_o == rwi_pkg::VEC_RESET && set_mask_o))
		else $error("reset vector wrong");
	AST_HOLD_PIN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state == ST_HOLD && !reset_pin_n) |=> state == ST_HOLD)
		else $error("left reset with pin low");
	AST_WDOG_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(wb_req && wb_we_i && wb_hit && wb_sel_i[0]
		&& !wb_dat_i[rwi_pkg::WDOG_CLEAR_BIT]
		&& state == ST_RUN && !wdog_expire) |=> wdog_cnt == '0)
		else $error("watchdog not cleared");
	AST_STOP_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state == ST_STOP && opt_wdog && !self_check_i)
		|=> wdog_cnt == STOP_CNT_W || sys_reset_o)
		else $error("stop count wrong");
	AST_WAIT_RUNS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state == ST_WAIT && $past(state) == ST_WAIT && opt_wdog
		&& !self_check_i && !wb_req && !$past(wb_req) && $past(wdog_cnt) != '0)
		|-> wdog_cnt != $past(wdog_cnt)) else $error("watchdog stalled");
	AST_OSC_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state == ST_STOP) |-> !osc_enable_o) else $error("osc on in stop");
	AST_TIMER_GATE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!timer_i.capture_en && !timer_i.compare_en && !timer_i.overflow_en)
		|-> !timer_req) else $error("disabled timer request");
	AST_RC_DELAY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rst_n_i && state == ST_POR && opt_rc && osc_active_i
		&& delay_cnt == '0 && !wdog_expire)
		##1 (osc_active_i && !wdog_expire)
		|=> state == ST_HOLD) else $error("rc delay wrong");

endmodule // rwi_ctrl

// ===== rwi_pkg.sv
// Package with constants, encodings and carrier structs for the reset, watchdog and interrupt block.
package rwi_pkg;

	// Register address and field layout of the watchdog clear register.
	localparam logic [12:0] WDOG_CLEAR_ADDR  = 13'h1ff0;
	localparam int          WDOG_CLEAR_BIT   = 0;
	localparam logic [7:0]  SELF_CHECK_CODE  = 8'h00;

	// Vector addresses, high byte location of each pair.
	localparam logic [12:0] VEC_RESET = 13'h1ffe;
	localparam logic [12:0] VEC_TRAP  = 13'h1ffc;
	localparam logic [12:0] VEC_EXT   = 13'h1ffa;
	localparam logic [12:0] VEC_TIMER = 13'h1ff8;

	// Watchdog and power-on timing, in bus cycles and counter stages, and the port A pin count.
	localparam int WDOG_STAGES    = 18;
	localparam int RC_DELAY_CYC   = 2;
	localparam int XTAL_DELAY_CYC = 4064;
	localparam int STOP_EXIT_CNT  = 4064;
	localparam int PORTA_PINS     = 6;

	// Bus clock rate and bus cycle time.
	localparam int CLK_HZ         = 25000000;
	localparam int BUS_CYCLE_NS   = 40;

	// Vector selection reported to the core.
	typedef enum logic [2:0] {
		RWI_VEC_NONE,
		RWI_VEC_RESET,
		RWI_VEC_TRAP,
		RWI_VEC_EXT,
		RWI_VEC_TIMER
	} rwi_vec_e;

	// Handshake from the processor core.
	typedef struct packed {
		logic boundary;
		logic trap_req;
		logic stop_req;
		logic wait_req;
		logic mask_clear;
		logic ack;
	} rwi_core_s;

	// Timer flags with their enables.
	typedef struct packed {
		logic capture_flag;
		logic compare_flag;
		logic overflow_flag;
		logic capture_en;
		logic compare_en;
		logic overflow_en;
	} rwi_timer_s;

endpackage

// ===== rwi_sync.sv
// Two-stage synchroniser for a bus of asynchronous pin levels.
`timescale 1ns/1ps
module rwi_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	// Clock and reset.
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Pin levels and synchronised copies.
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] stage1;

	// The first stage feeds only the second, so metastability stays contained.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stage1 <= INIT;
			sync_o <= INIT;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end

endmodule // rwi_sync

// ===== tb_rwi_ctrl.sv
// Self-checking testbench for the reset, watchdog and interrupt block.
`timescale 1ns/1ps
module tb_rwi_ctrl;
	logic			clk, rst_n, rc, wd, lvl, sc, osc, rpin, irq;
	logic			cyc, stb, we, ack, srst, smask, oscen, halt, rlev, rs_q;
	logic [5:0]		popt, pa, dir;
	logic [12:0]	adr, vao, vadr;
	logic [31:0]	wdat, rdat, x;
	logic [3:0]		cmd;
	logic [1:0]		lat;
	rwi_pkg::rwi_timer_s	tmr;
	rwi_pkg::rwi_core_s	core;
	rwi_pkg::rwi_vec_e	vsel, taken;
	int			takes, fails, comparisons, resets, cyc_n, n, t;

	rwi_ctrl #(.XTAL_DELAY(8), .STAGES(8)) dut (.clk_i(clk), .rst_n_i(rst_n),
		.opt_rc_osc_i(rc), .opt_wdog_en_i(wd), .opt_level_trig_i(lvl),
		.opt_porta_irq_i(popt), .self_check_i(sc), .osc_active_i(osc),
		.reset_pin_n_i(rpin), .irq_pin_n_i(irq), .porta_pin_i(pa),
		.porta_direction_register_i(dir), .timer_i(tmr), .core_i(core),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.sys_reset_o(srst), .set_mask_o(smask), .osc_enable_o(oscen),
		.core_halt_o(halt), .request_level_o(rlev), .vec_sel_o(vsel),
		.vec_addr_o(vao));

	rwi_core_model core_m (.clk_i(clk), .rst_n_i(rst_n), .vec_sel_i(vsel),
		.halt_i(halt), .cmd_i(cmd), .lat_i(lat), .core_o(core),
		.taken_o(taken), .takes_o(takes));

	// Clock of 40 ns period.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Cut a hang short and count entries into reset.
	always @(posedge clk) begin
		cyc_n++;
		rs_q <= srst;
		if (srst && !rs_q) resets++;
		if (cyc_n == 40000) begin
			fails++;
			tally_and_finish;
		end
	end

	task automatic tally_and_finish;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask

	// One classic cycle; the wait ends only on ack or the timeout.
	task automatic wb(input logic w, input logic [12:0] a,
		input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		x = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic pulse(input logic [3:0] c);
		@(posedge clk);
		cmd <= c;
		@(posedge clk);
		cmd <= 4'h0;
	endtask

	task automatic set_irq(input logic v);
		@(posedge clk);
		irq <= v;
	endtask

	task automatic irq_pulse;
		set_irq(1'b0);
		tick(3);
		set_irq(1'b1);
	endtask

	task automatic set_tmr(input logic [5:0] v);
		@(posedge clk);
		tmr <= v;
	endtask

	task automatic run_wait;
		for (n = 0; n < 60 && srst !== 1'b0; n++) @(negedge clk);
	endtask

	task automatic do_rst(input logic r, input logic w, input logic l);
		@(posedge clk);
		rst_n <= 1'b0;
		rc <= r;
		wd <= w;
		lvl <= l;
		tick(6);
		@(negedge clk);
		chk("rst_vec", rwi_pkg::RWI_VEC_RESET, vsel);
		chk("rst_adr", 13'h1ffe, vao);
		chk("rst_mask", 1, smask);
		@(posedge clk);
		rst_n <= 1'b1;
		run_wait;
	endtask

	// Wait for the core to take a vector and check which one it was.
	task automatic take(input rwi_pkg::rwi_vec_e e, input logic [12:0] ea);
		int t0;
		t0 = takes;
		vadr = 13'h0;
		for (int i = 0; i < 60 && takes == t0; i++) begin
			@(negedge clk);
			if (vsel === e) vadr = vao;
			if (core.ack === 1'b1) chk("set_mask", 1, smask);
		end
		chk("taken", e, taken);
		chk("vec_addr", ea, vadr);
	endtask

	task automatic none(input int k);
		int t0;
		t0 = takes;
		tick(k);
		@(negedge clk);
		chk("no_take", t0, takes);
	endtask

	initial begin
		rst_n = 1'b0;
		rc = 1'b1;
		wd = 1'b0;
		lvl = 1'b1;
		sc = 1'b0;
		osc = 1'b1;
		rpin = 1'b1;
		irq = 1'b1;
		popt = 6'h3f;
		pa = 6'h3f;
		dir = 6'h00;
		tmr = 6'h00;
		cmd = 4'h0;
		lat = 2'd0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 13'h0;
		wdat = 32'h0;
		// Power-up and register access.
		do_rst(1'b1, 1'b0, 1'b1);
		chk("rc_delay", 1, n >= 2 && n <= 6);
		wb(1'b0, 13'h1ff0, 32'h0);
		chk("self_chk", {24'h0, rwi_pkg::SELF_CHECK_CODE}, x);
		wb(1'b0, 13'h0123, 32'h0);
		chk("unmapped", 32'h0, x);
		@(posedge clk);
		rpin <= 1'b0;
		do_rst(1'b1, 1'b0, 1'b1);
		chk("pin_hold", 1, srst);
		@(posedge clk);
		rpin <= 1'b1;
		run_wait;
		chk("pin_free", 0, srst);
		do_rst(1'b0, 1'b0, 1'b1);
		chk("xtal_delay", 1, n >= 8 && n <= 16);
		// Masked requests, trap and priority.
		irq_pulse;
		none(10);
		pulse(4'h8);
		take(rwi_pkg::RWI_VEC_EXT, 13'h1ffa);
		lat = 2'd3;
		pulse(4'h1);
		take(rwi_pkg::RWI_VEC_TRAP, 13'h1ffc);
		irq_pulse;
		pulse(4'h1);
		take(rwi_pkg::RWI_VEC_TRAP, 13'h1ffc);
		pulse(4'h8);
		take(rwi_pkg::RWI_VEC_EXT, 13'h1ffa);
		// Each timer flag, first blocked by its enable.
		for (int i = 0; i < 3; i++) begin
			set_tmr(6'(8 << i));
			pulse(4'h8);
			none(8);
			set_tmr(6'(9 << i));
			take(rwi_pkg::RWI_VEC_TIMER, 13'h1ff8);
			set_tmr(6'h00);
		end
		// Level mode serves a held line again.
		set_irq(1'b0);
		pulse(4'h8);
		take(rwi_pkg::RWI_VEC_EXT, 13'h1ffa);
		pulse(4'h8);
		take(rwi_pkg::RWI_VEC_EXT, 13'h1ffa);
		set_irq(1'b1);
		// The line was still low at the last take, so one more is latched.
		tick(3);
		pulse(4'h8);
		take(rwi_pkg::RWI_VEC_EXT, 13'h1ffa);
		// Port A pin counts only when set as input.
		@(posedge clk);
		dir <= 6'h04;
		pa <= 6'h3b;
		pulse(4'h8);
		none(8);
		chk("req_level_out", 0, rlev);
		@(posedge clk);
		dir <= 6'h00;
		take(rwi_pkg::RWI_VEC_EXT, 13'h1ffa);
		chk("req_level_in", 1, rlev);
		@(posedge clk);
		pa <= 6'h3f;
		// The pin was low at the take, so a second request stays latched.
		pulse(4'h8);
		take(rwi_pkg::RWI_VEC_EXT, 13'h1ffa);
		// WAIT ends on a timer request, STOP only on an external one.
		lat = 2'd0;
		pulse(4'h4);
		none(4);
		chk("halt_wait", 1, halt);
		set_tmr(6'h09);
		take(rwi_pkg::RWI_VEC_TIMER, 13'h1ff8);
		chk("wait_exit", 0, halt);
		set_tmr(6'h00);
		pulse(4'h2);
		none(4);
		chk("osc_stop", 0, oscen);
		set_tmr(6'h09);
		none(10);
		chk("halt_stop", 1, halt);
		set_tmr(6'h00);
		irq_pulse;
		take(rwi_pkg::RWI_VEC_EXT, 13'h1ffa);
		chk("osc_run", 1, oscen);
		// Edge-only mode serves a held line once.
		do_rst(1'b1, 1'b0, 1'b0);
		set_irq(1'b0);
		pulse(4'h8);
		take(rwi_pkg::RWI_VEC_EXT, 13'h1ffa);
		pulse(4'h8);
		none(10);
		set_irq(1'b1);
		// Watchdog: cleared in time, then let run out.
		do_rst(1'b1, 1'b1, 1'b1);
		t = resets;
		repeat (6) begin
			tick(100);
			wb(1'b1, 13'h1ff0, 32'h0);
		end
		chk("wdog_held", t, resets);
		repeat (3) begin
			tick(100);
			wb(1'b1, 13'h1ff0, 32'h1);
		end
		chk("wdog_expiry", t + 1, resets);
		run_wait;
		wb(1'b1, 13'h1ff0, 32'h0);
		pulse(4'h4);
		tick(300);
		chk("wdog_in_wait", t + 2, resets);
		run_wait;
		// STOP holds the watchdog; an interrupt exit resumes near expiry.
		wb(1'b1, 13'h1ff0, 32'h0);
		pulse(4'h2);
		tick(300);
		chk("wdog_in_stop", t + 2, resets);
		irq_pulse;
		take(rwi_pkg::RWI_VEC_EXT, 13'h1ffa);
		tick(40);
		chk("wdog_stop_exit", t + 3, resets);
		run_wait;
		@(posedge clk);
		sc <= 1'b1;
		tick(600);
		chk("wdog_self_chk", t + 3, resets);
		tally_and_finish;
	end
endmodule // tb_rwi_ctrl
